//--- algo_tuning_config_regs.sv
// Tuning and hardware configuration register bank for the motor-control engine
`timescale 1ns/1ns
//
// Operation
// - Flux-weakening proportional gain from bits 30:21, scale over value, 0.1 factor.
// - Flux-weakening integral gain from bits 20:11, scale over value, 10.0 factor.
// - Flux weakening runs only while bit 10 is one.
// - Bits 9:6 pick the reduced acceleration just after entering closed loop.
// - That acceleration's unit follows the active control loop.
// - Bits 5:3 pick active-brake bus-current slew; code 7 means unlimited.
// - Bit 1 zero: estimation uses normal open-loop settings.
// - Bit 1 one: estimation uses its dedicated slew, current and speed fields.
// - Bit 0 selects high-resolution initial position detection.
// - Tuning register at A2h, all zero after reset.
// - Six hardware setup registers at even offsets A4h to AEh.
module algo_tuning_config_regs
    import tune_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    // Algorithm side
    input  wire loop_mode_t  loop_mode,
    output tuning_cfg_t      tuning_cfg,
    output logic             est_use_dedicated,
    output logic             parity_ok,
    output logic [31:0]      hw_pin_setup,
    output logic [31:0]      system_setup_a,
    output logic [31:0]      system_setup_b,
    output logic [31:0]      peripheral_setup_a,
    output logic [31:0]      gate_drive_setup_a,
    output logic [31:0]      gate_drive_setup_b
);

    logic [31:0] algo_tuning_two_r;
    logic [31:0] hw_setup_r [HW_COUNT];
    tuning_cfg_t cfg_nxt;

    // Index of a hardware setup register; valid only for an even offset in range
    function automatic logic hw_hit(input logic [7:0] a);
        logic [7:0] d;
        d = a - OFS_HW_FIRST;
        return (a >= OFS_HW_FIRST) && (a <= OFS_GATE_DRIVE_SETUP_B) && !d[0];
    endfunction : hw_hit

    function automatic logic [2:0] hw_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - OFS_HW_FIRST;
        return d[3:1];
    endfunction : hw_idx

    // Tuning register, parity kept as written
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            algo_tuning_two_r <= RST_ALGO_TUNING;
        else if (wr && addr == OFS_ALGO_TUNING_TWO)
            algo_tuning_two_r <= wdata;
    end

    // Hardware setup registers
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < HW_COUNT; i++)
                hw_setup_r[i] <= RST_HW_SETUP;
        end
        else if (wr && hw_hit(addr))
            hw_setup_r[hw_idx(addr)] <= wdata;
    end

    // Read data stands one cycle after the read strobe, zero otherwise
    always_ff @(posedge clk)
    begin
        if (!rst_b)
            rdata <= '0;
        else if (rd && addr == OFS_ALGO_TUNING_TWO)
            rdata <= algo_tuning_two_r;
        else if (rd && hw_hit(addr))
            rdata <= hw_setup_r[hw_idx(addr)];
        else
            rdata <= '0;
    end

    tuning_decode u_decode (
        .tuning_word (algo_tuning_two_r),
        .loop_mode   (loop_mode),
        .cfg         (cfg_nxt)
    );

    // Registered outputs to the control algorithm
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            tuning_cfg        <= '0;
            est_use_dedicated <= 1'b0;
            parity_ok         <= 1'b1;
        end
        else
        begin
            tuning_cfg        <= cfg_nxt;
            est_use_dedicated <= algo_tuning_two_r[BIT_EST_SRC];
            parity_ok         <= ~^algo_tuning_two_r;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            hw_pin_setup       <= RST_HW_SETUP;
            system_setup_a     <= RST_HW_SETUP;
            system_setup_b     <= RST_HW_SETUP;
            peripheral_setup_a <= RST_HW_SETUP;
            gate_drive_setup_a <= RST_HW_SETUP;
            gate_drive_setup_b <= RST_HW_SETUP;
        end
        else
        begin
            hw_pin_setup       <= hw_setup_r[0];
            system_setup_a     <= hw_setup_r[1];
            system_setup_b     <= hw_setup_r[2];
            peripheral_setup_a <= hw_setup_r[3];
            gate_drive_setup_a <= hw_setup_r[4];
            gate_drive_setup_b <= hw_setup_r[5];
        end
    end

    a_tuning_reset_zero: assert property (@(posedge clk)
        !rst_b |=> (algo_tuning_two_r == RST_ALGO_TUNING))
        else $error("tuning register not zero after reset");

    a_tuning_write_read: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && addr == OFS_ALGO_TUNING_TWO) ##1 (rd && addr == OFS_ALGO_TUNING_TWO)
        |=> (rdata == $past(wdata, 2)))
        else $error("tuning word not read back as written");

    a_fw_enable_path: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && addr == OFS_ALGO_TUNING_TWO)
        |-> ##2 (tuning_cfg.fw_enable == $past(wdata[BIT_FW_EN], 2)))
        else $error("flux weakening enable not following bit 10");

    a_kp_field_path: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && addr == OFS_ALGO_TUNING_TWO) |-> ##2
        (tuning_cfg.fw_prop_gain == $past(wdata[FW_KP_HI:FW_KP_LO], 2)))
        else $error("proportional gain field mismatch");

    a_ki_field_path: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && addr == OFS_ALGO_TUNING_TWO) |-> ##2
        (tuning_cfg.fw_integral_gain == $past(wdata[FW_KI_HI:FW_KI_LO], 2)))
        else $error("integral gain field mismatch");

    a_brake_no_limit: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && addr == OFS_ALGO_TUNING_TWO && wdata[BRK_SLEW_HI:BRK_SLEW_LO] == BRK_SLEW_NO_LIMIT)
        |-> ##2 tuning_cfg.brake_slew_unlimited)
        else $error("brake slew code 7 not unlimited");

    a_accel_code_max: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && addr == OFS_ALGO_TUNING_TWO && wdata[CL_ACC_HI:CL_ACC_LO] == 4'hF)
        |-> ##2 (tuning_cfg.closed_loop_initial_accel == 15'h4E20))
        else $error("slow acceleration code F not 2000");

    a_estimate_source: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && addr == OFS_ALGO_TUNING_TWO) |-> ##2
        (est_use_dedicated == $past(wdata[BIT_EST_SRC], 2)))
        else $error("estimation source select mismatch");

    a_fine_detect: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && addr == OFS_ALGO_TUNING_TWO) |-> ##2
        (tuning_cfg.position_detect_fine_en == $past(wdata[BIT_IPD_FINE], 2)))
        else $error("position detect resolution mismatch");

    a_hw_odd_ignored: assert property (@(posedge clk) disable iff (!rst_b)
        (rd && addr == 8'hA5) |=> (rdata == 32'h0000_0000))
        else $error("odd hardware offset not reading zero");

    a_unit_follows: assert property (@(posedge clk) disable iff (!rst_b)
        (rst_b && loop_mode == LOOP_VOLTAGE) |=> (tuning_cfg.accel_unit == UNIT_MI_PER_S))
        else $error("acceleration unit not following loop");

    a_unit_speed: assert property (@(posedge clk) disable iff (!rst_b)
        (rst_b && loop_mode == LOOP_SPEED)
        |=> (tuning_cfg.accel_unit == UNIT_HZ_PER_S))
        else $error("speed loop unit not hertz per second");

    a_unit_power: assert property (@(posedge clk) disable iff (!rst_b)
        (rst_b && loop_mode == LOOP_POWER)
        |=> (tuning_cfg.accel_unit == UNIT_W_PER_S))
        else $error("power loop unit not watts per second");

    a_unit_current: assert property (@(posedge clk) disable iff (!rst_b)
        (rst_b && loop_mode == LOOP_CURRENT)
        |=> (tuning_cfg.accel_unit == UNIT_A_PER_S))
        else $error("current loop unit not amperes per second");

    a_pin_setup_out: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && addr == OFS_HW_PIN_SETUP)
        |-> ##2 (hw_pin_setup == $past(wdata, 2)))
        else $error("pin setup output not following write");

    a_sys_a_out: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && addr == OFS_SYSTEM_SETUP_A)
        |-> ##2 (system_setup_a == $past(wdata, 2)))
        else $error("first system setup output not following write");

    a_sys_b_out: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && addr == OFS_SYSTEM_SETUP_B)
        |-> ##2 (system_setup_b == $past(wdata, 2)))
        else $error("second system setup output not following write");

    a_periph_out: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && addr == OFS_PERIPHERAL_SETUP_A)
        |-> ##2 (peripheral_setup_a == $past(wdata, 2)))
        else $error("peripheral setup output not following write");

    a_gate_a_out: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && addr == OFS_GATE_DRIVE_SETUP_A)
        |-> ##2 (gate_drive_setup_a == $past(wdata, 2)))
        else $error("first gate drive output not following write");

    a_gate_b_out: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && addr == OFS_GATE_DRIVE_SETUP_B)
        |-> ##2 (gate_drive_setup_b == $past(wdata, 2)))
        else $error("second gate drive output not following write");

    a_tuning_read: assert property (@(posedge clk) disable iff (!rst_b)
        (rd && addr == OFS_ALGO_TUNING_TWO)
        |=> (rdata == $past(algo_tuning_two_r)))
        else $error("tuning read not returning stored word");

    a_gate_b_read: assert property (@(posedge clk) disable iff (!rst_b)
        (rd && addr == OFS_GATE_DRIVE_SETUP_B)
        |=> (rdata == $past(hw_setup_r[hw_idx(OFS_GATE_DRIVE_SETUP_B)])))
        else $error("gate drive read not returning stored word");

    a_reserved_read_zero: assert property (@(posedge clk) disable iff (!rst_b)
        (rd && addr != OFS_ALGO_TUNING_TWO && !hw_hit(addr))
        |=> (rdata == '0))
        else $error("unassigned offset not reading zero");

    a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_b)
        (rst_b && !rd)
        |=> (rdata == '0))
        else $error("read data not zero without a read");

    a_no_write_hold: assert property (@(posedge clk) disable iff (!rst_b)
        (rst_b && !(wr && addr == OFS_ALGO_TUNING_TWO))
        |=> $stable(algo_tuning_two_r))
        else $error("tuning register changed without a write");

    a_parity_track: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && addr == OFS_ALGO_TUNING_TWO)
        |-> ##2 (parity_ok == ~^$past(wdata, 2)))
        else $error("parity flag not tracking stored word");

    a_slew_code_zero: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && addr == OFS_ALGO_TUNING_TWO && wdata[BRK_SLEW_HI:BRK_SLEW_LO] == '0)
        |-> ##2 (tuning_cfg.brake_slew_aps == BRK_SLEW_APS[0]))
        else $error("brake slew code 0 not lowest rate");

    a_slew_limited: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && addr == OFS_ALGO_TUNING_TWO && wdata[BRK_SLEW_HI:BRK_SLEW_LO] != BRK_SLEW_NO_LIMIT)
        |-> ##2 !tuning_cfg.brake_slew_unlimited)
        else $error("limited brake slew code marked unlimited");

    a_accel_code_zero: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && addr == OFS_ALGO_TUNING_TWO && wdata[CL_ACC_HI:CL_ACC_LO] == '0)
        |-> ##2 (tuning_cfg.closed_loop_initial_accel == CL_ACC_TENTHS[0]))
        else $error("slow acceleration code 0 not lowest rate");

    a_fw_disabled: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && addr == OFS_ALGO_TUNING_TWO && !wdata[BIT_FW_EN])
        |-> ##2 !tuning_cfg.fw_enable)
        else $error("flux weakening enabled with bit 10 clear");

    a_est_source_cfg: assert property (@(posedge clk) disable iff (!rst_b)
        (wr && addr == OFS_ALGO_TUNING_TWO)
        |-> ##2 (tuning_cfg.estimation_param_source == $past(wdata[BIT_EST_SRC], 2)))
        else $error("estimation source field mismatch");

    a_cfg_reset_zero: assert property (@(posedge clk)
        !rst_b
        |=> (tuning_cfg == '0))
        else $error("decoded settings not cleared by reset");

    a_rdata_reset_zero: assert property (@(posedge clk)
        !rst_b
        |=> (rdata == '0))
        else $error("read data not cleared by reset");

    a_parity_reset_ok: assert property (@(posedge clk)
        !rst_b
        |=> parity_ok)
        else $error("parity flag not set for cleared word");

    a_hw_reset_zero: assert property (@(posedge clk)
        !rst_b
        |=> (hw_pin_setup == RST_HW_SETUP && gate_drive_setup_b == RST_HW_SETUP))
        else $error("hardware setup outputs not cleared by reset");

endmodule : algo_tuning_config_regs

//--- tune_pkg.sv
// Register map, field layout and decode tables for the algorithm tuning register bank
package tune_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // Register offsets (printed offsets are byte addresses on this plain port)
    localparam logic [7:0] OFS_ALGO_TUNING_TWO    = 8'hA2;
    localparam logic [7:0] OFS_HW_PIN_SETUP       = 8'hA4;
    localparam logic [7:0] OFS_SYSTEM_SETUP_A     = 8'hA6;
    localparam logic [7:0] OFS_SYSTEM_SETUP_B     = 8'hA8;
    localparam logic [7:0] OFS_PERIPHERAL_SETUP_A = 8'hAA;
    localparam logic [7:0] OFS_GATE_DRIVE_SETUP_A = 8'hAC;
    localparam logic [7:0] OFS_GATE_DRIVE_SETUP_B = 8'hAE;
    localparam logic [7:0] OFS_HW_FIRST           = OFS_HW_PIN_SETUP;
    localparam int unsigned HW_COUNT = 6;

    // Reset values
    localparam logic [31:0] RST_ALGO_TUNING = 32'h0000_0000;
    localparam logic [31:0] RST_HW_SETUP    = 32'h0000_0000;

    // Field positions in the tuning register
    localparam int unsigned BIT_PARITY      = 31;
    localparam int unsigned FW_KP_HI        = 30;
    localparam int unsigned FW_KP_LO        = 21;
    localparam int unsigned FW_KI_HI        = 20;
    localparam int unsigned FW_KI_LO        = 11;
    localparam int unsigned BIT_FW_EN       = 10;
    localparam int unsigned CL_ACC_HI       = 9;
    localparam int unsigned CL_ACC_LO       = 6;
    localparam int unsigned BRK_SLEW_HI     = 5;
    localparam int unsigned BRK_SLEW_LO     = 3;
    localparam int unsigned BIT_EST_SRC     = 1;
    localparam int unsigned BIT_IPD_FINE    = 0;

    // Gain field split: two-bit decimal scale over eight-bit value
    typedef struct packed {
        logic [1:0] scale;
        logic [7:0] value;
    } gain_field_t;

    // Closed-loop initial acceleration, in tenths of a unit per second
    localparam logic [14:0] CL_ACC_TENTHS [16] = '{
        15'h0001, 15'h000A, 15'h0014, 15'h001E, 15'h0032, 15'h0064, 15'h00C8, 15'h012C,
        15'h0190, 15'h01F4, 15'h03E8, 15'h07D0, 15'h1388, 15'h1D4C, 15'h2710, 15'h4E20
    };

    // Active-brake bus-current slew in A/s; code 7 is no limit
    localparam logic [12:0] BRK_SLEW_APS [8] = '{
        13'h000A, 13'h0032, 13'h0064, 13'h00FA, 13'h01F4, 13'h03E8, 13'h1388, 13'h0000
    };
    localparam logic [2:0] BRK_SLEW_NO_LIMIT = 3'h7;

    // Control loop selecting the unit of the slow acceleration
    typedef enum logic [1:0] {
        LOOP_SPEED   = 2'b00,
        LOOP_POWER   = 2'b01,
        LOOP_CURRENT = 2'b10,
        LOOP_VOLTAGE = 2'b11
    } loop_mode_t;

    typedef enum logic [1:0] {
        UNIT_HZ_PER_S   = 2'b00,
        UNIT_W_PER_S    = 2'b01,
        UNIT_A_PER_S    = 2'b10,
        UNIT_MI_PER_S   = 2'b11
    } accel_unit_t;

    // Decoded settings handed to the control algorithm
    typedef struct packed {
        gain_field_t fw_prop_gain;
        gain_field_t fw_integral_gain;
        logic        fw_enable;
        logic [14:0] closed_loop_initial_accel;
        accel_unit_t accel_unit;
        logic [12:0] brake_slew_aps;
        logic        brake_slew_unlimited;
        logic        estimation_param_source;
        logic        position_detect_fine_en;
    } tuning_cfg_t;

    // Register port request
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

endpackage : tune_pkg

//--- tuning_decode.sv
// Decodes the tuning word into the settings used by the control algorithm
`timescale 1ns/1ns
module tuning_decode
    import tune_pkg::*;
(
    // Register contents and active loop
    input  wire logic [31:0] tuning_word,
    input  wire loop_mode_t  loop_mode,
    // Decoded settings
    output tuning_cfg_t      cfg
);

    always_comb
    begin
        cfg                           = '0;
        cfg.fw_prop_gain              = tuning_word[FW_KP_HI:FW_KP_LO];
        cfg.fw_integral_gain          = tuning_word[FW_KI_HI:FW_KI_LO];
        cfg.fw_enable                 = tuning_word[BIT_FW_EN];
        cfg.closed_loop_initial_accel = CL_ACC_TENTHS[tuning_word[CL_ACC_HI:CL_ACC_LO]];
        unique case (loop_mode)
            LOOP_SPEED:   cfg.accel_unit = UNIT_HZ_PER_S;
            LOOP_POWER:   cfg.accel_unit = UNIT_W_PER_S;
            LOOP_CURRENT: cfg.accel_unit = UNIT_A_PER_S;
            LOOP_VOLTAGE: cfg.accel_unit = UNIT_MI_PER_S;
        endcase
        cfg.brake_slew_aps            = BRK_SLEW_APS[tuning_word[BRK_SLEW_HI:BRK_SLEW_LO]];
        cfg.brake_slew_unlimited      =
            (tuning_word[BRK_SLEW_HI:BRK_SLEW_LO] == BRK_SLEW_NO_LIMIT);
        cfg.estimation_param_source   = tuning_word[BIT_EST_SRC];
        cfg.position_detect_fine_en   = tuning_word[BIT_IPD_FINE];
    end

endmodule : tuning_decode

//--- tb_top.sv
// Self-checking testbench for the tuning and hardware configuration register bank
`timescale 1ns/1ns
module tb_top;
    import tune_pkg::*;

    logic        clk;
    logic        rst_b;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    loop_mode_t  loop_mode;
    tuning_cfg_t tuning_cfg;
    logic        est_use_dedicated;
    logic        parity_ok;
    logic [31:0] hw_out [6];
    int          bad_count;
    int          cmp_count;
    logic [31:0] w;

    // Expected decode tables, in tenths of a unit per second and in A/s
    logic [14:0] acc_exp [16] = '{15'h0001, 15'h000A, 15'h0014, 15'h001E, 15'h0032,
        15'h0064, 15'h00C8, 15'h012C, 15'h0190, 15'h01F4, 15'h03E8, 15'h07D0, 15'h1388,
        15'h1D4C, 15'h2710, 15'h4E20};
    logic [12:0] slew_exp [8] = '{13'h000A, 13'h0032, 13'h0064, 13'h00FA, 13'h01F4,
        13'h03E8, 13'h1388, 13'h0000};

    algo_tuning_config_regs algo_tuning_config_regs_i (
        .clk                (clk),
        .rst_b              (rst_b),
        .addr               (addr),
        .wdata              (wdata),
        .wr                 (wr),
        .rd                 (rd),
        .rdata              (rdata),
        .loop_mode          (loop_mode),
        .tuning_cfg         (tuning_cfg),
        .est_use_dedicated  (est_use_dedicated),
        .parity_ok          (parity_ok),
        .hw_pin_setup       (hw_out[0]),
        .system_setup_a     (hw_out[1]),
        .system_setup_b     (hw_out[2]),
        .peripheral_setup_a (hw_out[3]),
        .gate_drive_setup_a (hw_out[4]),
        .gate_drive_setup_b (hw_out[5])
    );

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One-cycle write, strobe dropped on the following edge
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe, then return to zero
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1 chk("rdata", exp, rdata);
        @(posedge clk);
        #1 chk("rdata idle", 32'h0000_0000, rdata);
    endtask : rd_chk

    // Write then read with no gap between the strobes
    task automatic wr_then_rd(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        rd    <= 1'b1;
        @(posedge clk);
        rd    <= 1'b0;
        #1 chk("rdata b2b", d, rdata);
    endtask : wr_then_rd

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    initial
    begin
        bad_count = 0;
        cmp_count = 0;
        rst_b     = 1'b0;
        addr      = 8'h00;
        wdata     = 32'h0000_0000;
        wr        = 1'b0;
        rd        = 1'b0;
        loop_mode = LOOP_SPEED;
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(OFS_ALGO_TUNING_TWO, 32'h0000_0000);
        rd_chk(OFS_HW_PIN_SETUP, 32'h0000_0000);
        chk("parity_ok reset", 32'h0000_0001, {31'h0, parity_ok});
        // Gains, enables, source select and parity over two words opposite in every bit but bit 2
        foreach (acc_exp[k])
        begin
            if (k > 1)
                break;
            w = (k == 0) ? 32'h9234_5603 : 32'h6DCB_A9F8;
            wr_reg(OFS_ALGO_TUNING_TWO, w);
            settle();
            chk("kp scale", {30'h0, w[30:29]}, {30'h0, tuning_cfg.fw_prop_gain.scale});
            chk("kp value", {24'h0, w[28:21]}, {24'h0, tuning_cfg.fw_prop_gain.value});
            chk("ki scale", {30'h0, w[20:19]}, {30'h0, tuning_cfg.fw_integral_gain.scale});
            chk("ki value", {24'h0, w[18:11]}, {24'h0, tuning_cfg.fw_integral_gain.value});
            chk("fw enable", {31'h0, w[10]}, {31'h0, tuning_cfg.fw_enable});
            chk("src cfg", {31'h0, w[1]}, {31'h0, tuning_cfg.estimation_param_source});
            chk("dedicated", {31'h0, w[1]}, {31'h0, est_use_dedicated});
            chk("fine pos", {31'h0, w[0]}, {31'h0, tuning_cfg.position_detect_fine_en});
            chk("parity_ok", {31'h0, ~^w}, {31'h0, parity_ok});
            rd_chk(OFS_ALGO_TUNING_TWO, w);
        end
        // Every acceleration code and every brake slew code
        for (int i = 0; i < 16; i++)
        begin
            w = 32'h0000_0000;
            w[9:6] = i[3:0];
            w[5:3] = i[2:0];
            wr_reg(OFS_ALGO_TUNING_TWO, w);
            settle();
            chk("accel", {17'h0, acc_exp[i]}, {17'h0, tuning_cfg.closed_loop_initial_accel});
            chk("slew", {19'h0, slew_exp[i % 8]}, {19'h0, tuning_cfg.brake_slew_aps});
            chk("no limit", {31'h0, i[2:0] == 3'h7}, {31'h0, tuning_cfg.brake_slew_unlimited});
        end
        // Unit follows each control loop
        for (int m = 0; m < 4; m++)
        begin
            @(posedge clk);
            loop_mode <= loop_mode_t'(m[1:0]);
            settle();
            chk("unit", m, {30'h0, tuning_cfg.accel_unit});
        end
        // Six hardware registers, read back and on their outputs
        for (int k = 0; k < 6; k++)
            wr_reg(OFS_HW_FIRST + 8'(2 * k), 32'h1111_1111 * (k + 1));
        settle();
        for (int k = 0; k < 6; k++)
        begin
            rd_chk(OFS_HW_FIRST + 8'(2 * k), 32'h1111_1111 * (k + 1));
            chk("hw out", 32'h1111_1111 * (k + 1), hw_out[k]);
        end
        // Unassigned offsets are left unwritten and read as zero
        foreach (acc_exp[k])
        begin
            if (k > 3)
                break;
            w[7:0] = (k == 0) ? 8'hA0 : (k == 1) ? 8'hA3 : (k == 2) ? 8'hA5 : 8'hB0;
            rd_chk(w[7:0], 32'h0000_0000);
        end
        rd_chk(OFS_HW_PIN_SETUP, 32'h1111_1111);
        rd_chk(OFS_GATE_DRIVE_SETUP_B, 32'h6666_6666);
        // Strobes back to back: a read right behind its write sees the new word
        wr_then_rd(OFS_ALGO_TUNING_TWO, 32'h5A5A_0F0F);
        wr_then_rd(OFS_PERIPHERAL_SETUP_A, 32'hA5A5_F0F0);
        // Reset in mid-run clears everything again
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        rd_chk(OFS_ALGO_TUNING_TWO, 32'h0000_0000);
        rd_chk(OFS_SYSTEM_SETUP_A, 32'h0000_0000);
        chk("kp reset", 32'h0000_0000, {22'h0, tuning_cfg.fw_prop_gain});
        chk("hw out reset", 32'h0000_0000, hw_out[3]);
        close_out();
    end
endmodule : tb_top
